//--- rtl/tsp_regs.vh
// Register offsets, field positions, reset values and source codes of the timing pin block
`ifndef TSP_REGS_VH
`define TSP_REGS_VH

// Register offsets
`define TSP_OFF_PIN_CTRL   8'h02
`define TSP_OFF_PIN_SEL    8'h0B
`define TSP_OFF_AUX_CFG    8'h4F

// Pin output control fields
`define TSP_BIT_POL_FIRST  0
`define TSP_BIT_OD_FIRST   1
`define TSP_BIT_EN_FIRST   2
`define TSP_BIT_POL_SECOND 8
`define TSP_BIT_OD_SECOND  9

// Auxiliary configuration field
`define TSP_BIT_EN_SECOND  6

// Signal select fields
`define TSP_SEL_FIRST_LSB  0
`define TSP_SEL_SECOND_LSB 8
`define TSP_SEL_W          5

// Reset values
`define TSP_RST_PIN_CTRL   16'h0000
`define TSP_RST_PIN_SEL    16'h0000
`define TSP_RST_AUX_CFG    16'h0000

// Source codes of the select fields
`define TSP_SRC_IRQ        5'h01
`define TSP_SRC_ENVELOPE   5'h02
`define TSP_SRC_LED_A      5'h05
`define TSP_SRC_LED_B      5'h06
`define TSP_SRC_LED_AB     5'h07
`define TSP_SRC_WR_A       5'h0C
`define TSP_SRC_WR_B       5'h0D
`define TSP_SRC_WR_ANY     5'h0E
`define TSP_SRC_HALF_RATE  5'h0F
`define TSP_SRC_LOGIC0     5'h10
`define TSP_SRC_LOGIC1     5'h11
`define TSP_SRC_OSC        5'h13

// Synchroniser depth for signals from the slow and sequencer clocks
`define TSP_SYNC_STAGES    2

`endif

//--- rtl/tsp_pad.v
// One timing output pin: source select, polarity and drive control
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.vh"

module tsp_pad #(
  parameter SEL_W = 5
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // Pin configuration
  input  wire [SEL_W-1:0] sel,
  input  wire             pol_low,
  input  wire             od_mode,
  input  wire             drv_en,
  // Candidate timing signals
  input  wire             src_irq,
  input  wire             src_env,
  input  wire             src_led_a,
  input  wire             src_led_b,
  input  wire             src_wr_a,
  input  wire             src_wr_b,
  input  wire             src_wr_any,
  input  wire             src_half,
  input  wire             src_osc,
  // Pad signals
  output reg              pin_o,
  output reg              pin_oe
);

  wire raw;
  wire lvl;

  // Unknown codes give the deasserted level
  function pick;
    input [SEL_W-1:0] code;
    input             irq, env, la, lb, wa, wb, wn, hf, osc;
    begin
      case (code)
        `TSP_SRC_IRQ:       pick = irq;
        `TSP_SRC_ENVELOPE:  pick = env;
        `TSP_SRC_LED_A:     pick = la;
        `TSP_SRC_LED_B:     pick = lb;
        `TSP_SRC_LED_AB:    pick = la | lb;
        `TSP_SRC_WR_A:      pick = wa;
        `TSP_SRC_WR_B:      pick = wb;
        `TSP_SRC_WR_ANY:    pick = wn;
        `TSP_SRC_HALF_RATE: pick = hf;
        `TSP_SRC_LOGIC0:    pick = 1'b0;
        `TSP_SRC_LOGIC1:    pick = 1'b1;
        `TSP_SRC_OSC:       pick = osc;
        default:            pick = 1'b0;
      endcase
    end
  endfunction

  assign raw = pick(sel, src_irq, src_env, src_led_a, src_led_b,
                    src_wr_a, src_wr_b, src_wr_any, src_half, src_osc);
  // Polarity first, then drive decision uses the asserted state
  assign lvl = raw ^ pol_low;

  // Registered pad; open-drain mode drives only while asserted
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o  <= lvl;
      pin_oe <= drv_en & (~od_mode | raw);
    end
  end

endmodule
`default_nettype wire

//--- rtl/tsp_top.v
// Timing signal output pins: registers, sample event tracking and two pads
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.vh"

module tsp_top #(
  parameter ADDR_W = 8,
  parameter DATA_W = 16
) (
  // Clock and reset
  input  wire              sys_clk,
  input  wire              rst,
  // Register access port
  input  wire              reg_wr_en,
  input  wire              reg_rd_en,
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [DATA_W-1:0] reg_wr_data,
  output reg  [DATA_W-1:0] reg_rd_data,
  output reg               reg_rd_valid,
  // Same-clock inputs from the device core
  input  wire              dev_irq,
  input  wire              slot_a_en,
  input  wire              slot_b_en,
  // Inputs from the 32 kHz and 32 MHz time bases
  input  wire              run_mode,
  input  wire              slot_a_busy,
  input  wire              slot_b_busy,
  input  wire              led_a,
  input  wire              led_b,
  input  wire              data_a_tgl,
  input  wire              data_b_tgl,
  input  wire              osc_32k,
  // First timing pin
  output wire              aux_out_first,
  output wire              aux_out_first_oe,
  // Second timing pin
  output wire              aux_out_second,
  output wire              aux_out_second_oe
);

  localparam NSYNC = 8;

  // Positions inside the synchroniser vector
  localparam S_RUN   = 0;
  localparam S_ABUSY = 1;
  localparam S_BBUSY = 2;
  localparam S_LEDA  = 3;
  localparam S_LEDB  = 4;
  localparam S_TGLA  = 5;
  localparam S_TGLB  = 6;
  localparam S_OSC   = 7;

  // Configuration registers
  reg  [DATA_W-1:0] pin_output_control_q;
  reg  [DATA_W-1:0] pin_signal_select_q;
  reg               aux_drive_second_q;

  // Synchroniser and history stages
  reg  [NSYNC-1:0]  sync_meta_q;
  reg  [NSYNC-1:0]  sync_q;
  reg  [NSYNC-1:0]  hist_q;

  // Event state
  reg               envelope_q;
  reg               wr_a_q;
  reg               wr_b_q;
  reg               wr_any_q;
  reg               half_rate_q;

  // Decode and edge terms
  wire              hit_ctrl;
  wire              hit_sel;
  wire              hit_aux;
  wire              a_rise;
  wire              a_fall;
  wire              b_rise;
  wire              b_fall;
  wire              first_start;
  wire              last_end;
  wire              data_a_evt;
  wire              data_b_evt;
  wire              leaving_standby;
  wire [NSYNC-1:0]  async_in;

  // Address match shared by write and read paths
  function addr_is;
    input [ADDR_W-1:0] a;
    input [7:0]        off;
    begin
      addr_is = (a == off[ADDR_W-1:0]);
    end
  endfunction

  // Edge terms of one synchronised bit against its history copy
  function rose;
    input cur;
    input prev;
    begin
      rose = cur & ~prev;
    end
  endfunction

  function fell;
    input cur;
    input prev;
    begin
      fell = ~cur & prev;
    end
  endfunction

  // Any change of a toggle line marks one event
  function flipped;
    input cur;
    input prev;
    begin
      flipped = cur ^ prev;
    end
  endfunction

  assign hit_ctrl = addr_is(reg_addr, `TSP_OFF_PIN_CTRL);
  assign hit_sel  = addr_is(reg_addr, `TSP_OFF_PIN_SEL);
  assign hit_aux  = addr_is(reg_addr, `TSP_OFF_AUX_CFG);

  // Writes land on the strobe edge; the pads show new settings one
  // edge later, since every pin level leaves through a flop
  // Pin output control: only polarity, mode and enable bits are kept
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_output_control_q <= `TSP_RST_PIN_CTRL;
    end else if (reg_wr_en && hit_ctrl) begin
      pin_output_control_q <= 16'h0000;
      pin_output_control_q[`TSP_BIT_POL_FIRST]  <= reg_wr_data[`TSP_BIT_POL_FIRST];
      pin_output_control_q[`TSP_BIT_OD_FIRST]   <= reg_wr_data[`TSP_BIT_OD_FIRST];
      pin_output_control_q[`TSP_BIT_EN_FIRST]   <= reg_wr_data[`TSP_BIT_EN_FIRST];
      pin_output_control_q[`TSP_BIT_POL_SECOND] <= reg_wr_data[`TSP_BIT_POL_SECOND];
      pin_output_control_q[`TSP_BIT_OD_SECOND]  <= reg_wr_data[`TSP_BIT_OD_SECOND];
    end
  end

  // Signal select: two 5-bit fields, other bits read as zero
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_signal_select_q <= `TSP_RST_PIN_SEL;
    end else if (reg_wr_en && hit_sel) begin
      pin_signal_select_q <= 16'h0000;
      pin_signal_select_q[`TSP_SEL_FIRST_LSB +: `TSP_SEL_W] <=
        reg_wr_data[`TSP_SEL_FIRST_LSB +: `TSP_SEL_W];
      pin_signal_select_q[`TSP_SEL_SECOND_LSB +: `TSP_SEL_W] <=
        reg_wr_data[`TSP_SEL_SECOND_LSB +: `TSP_SEL_W];
    end
  end

  // Second pin drive enable lives in a separate configuration register
  always @(posedge sys_clk) begin
    if (rst) begin
      aux_drive_second_q <= 1'b0;
    end else if (reg_wr_en && hit_aux) begin
      aux_drive_second_q <= reg_wr_data[`TSP_BIT_EN_SECOND];
    end
  end

  // Data drops back to zero after the valid cycle, so nothing stale leaks
  // Registered read; unmapped addresses return zero
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rd_data  <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (!reg_rd_en) begin
        reg_rd_data <= 16'h0000;
      end else if (hit_ctrl) begin
        reg_rd_data <= pin_output_control_q;
      end else if (hit_sel) begin
        reg_rd_data <= pin_signal_select_q;
      end else if (hit_aux) begin
        reg_rd_data <= {9'h000, aux_drive_second_q, 6'h00};
      end else begin
        reg_rd_data <= 16'h0000;
      end
    end
  end

  // Async levels gathered in synchroniser order
  assign async_in = {osc_32k, data_b_tgl, data_a_tgl, led_b, led_a,
                     slot_b_busy, slot_a_busy, run_mode};

  // Two-flop synchronisers; the sample sequencer runs on the 32 kHz base
  // and the LED and capture strobes on the 32 MHz base.
  // No reset here: the stages keep sampling while reset is held, so a
  // toggle line left high cannot look like a fresh event on release
  always @(posedge sys_clk) begin
    sync_meta_q <= async_in;
    sync_q      <= sync_meta_q;
  end

  // History stage for edge detection, fed only from the second flop;
  // it also runs through reset so it matches the live levels
  always @(posedge sys_clk) begin
    hist_q <= sync_q;
  end

  // Slot edges
  assign a_rise = rose(sync_q[S_ABUSY], hist_q[S_ABUSY]);
  assign a_fall = fell(sync_q[S_ABUSY], hist_q[S_ABUSY]);
  assign b_rise = rose(sync_q[S_BBUSY], hist_q[S_BBUSY]);
  assign b_fall = fell(sync_q[S_BBUSY], hist_q[S_BBUSY]);

  // Sample starts with slot A when enabled, else with slot B;
  // it ends with slot B when enabled, else with slot A
  assign first_start = slot_a_en ? a_rise : (slot_b_en & b_rise);
  assign last_end    = slot_b_en ? b_fall : (slot_a_en & a_fall);

  // Data-stored events arrive as toggles, so no pulse is lost in crossing;
  // two toggles inside one clock would cancel each other
  assign data_a_evt = flipped(sync_q[S_TGLA], hist_q[S_TGLA]);
  assign data_b_evt = flipped(sync_q[S_TGLB], hist_q[S_TGLB]);

  // Standby exit seen as the rising edge of the run level
  assign leaving_standby = rose(sync_q[S_RUN], hist_q[S_RUN]);

  // All slot events lag the sequencer by the synchroniser depth,
  // a few system clocks, which is small next to one slot
  // Sample envelope; a single enabled slot opens and closes it alone
  always @(posedge sys_clk) begin
    if (rst) begin
      envelope_q <= 1'b0;
    end else if (first_start) begin
      envelope_q <= 1'b1;
    end else if (last_end) begin
      envelope_q <= 1'b0;
    end
  end

  // Slot A data flag: set wins over the sample-start clear
  always @(posedge sys_clk) begin
    if (rst) begin
      wr_a_q <= 1'b0;
    end else if (data_a_evt) begin
      wr_a_q <= 1'b1;
    end else if (first_start) begin
      wr_a_q <= 1'b0;
    end
  end

  // Slot B data flag, same timing
  always @(posedge sys_clk) begin
    if (rst) begin
      wr_b_q <= 1'b0;
    end else if (data_b_evt) begin
      wr_b_q <= 1'b1;
    end else if (first_start) begin
      wr_b_q <= 1'b0;
    end
  end

  // Either-slot flag rises on the first write of the sample
  always @(posedge sys_clk) begin
    if (rst) begin
      wr_any_q <= 1'b0;
    end else if (data_a_evt || data_b_evt) begin
      wr_any_q <= 1'b1;
    end else if (first_start) begin
      wr_any_q <= 1'b0;
    end
  end

  // Run already high when reset lifts counts as running, no exit edge
  // Half-rate wave: held low in standby and at standby exit,
  // toggles each time a sample completes while running
  always @(posedge sys_clk) begin
    if (rst) begin
      half_rate_q <= 1'b0;
    end else if (!sync_q[S_RUN] || leaving_standby) begin
      half_rate_q <= 1'b0;
    end else if (last_end) begin
      half_rate_q <= ~half_rate_q;
    end
  end

  // Both pads share every source; only select, polarity, mode and enable differ
  // First pin: enable from the pin control register
  tsp_pad #(
    .SEL_W      (`TSP_SEL_W)
  ) u_pad_first (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .sel        (pin_signal_select_q[`TSP_SEL_FIRST_LSB +: `TSP_SEL_W]),
    .pol_low    (pin_output_control_q[`TSP_BIT_POL_FIRST]),
    .od_mode    (pin_output_control_q[`TSP_BIT_OD_FIRST]),
    .drv_en     (pin_output_control_q[`TSP_BIT_EN_FIRST]),
    .src_irq    (dev_irq),
    .src_env    (envelope_q),
    .src_led_a  (sync_q[S_LEDA]),
    .src_led_b  (sync_q[S_LEDB]),
    .src_wr_a   (wr_a_q),
    .src_wr_b   (wr_b_q),
    .src_wr_any (wr_any_q),
    .src_half   (half_rate_q),
    .src_osc    (sync_q[S_OSC]),
    .pin_o      (aux_out_first),
    .pin_oe     (aux_out_first_oe)
  );

  // Second pin: enable from the separate configuration register
  tsp_pad #(
    .SEL_W      (`TSP_SEL_W)
  ) u_pad_second (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .sel        (pin_signal_select_q[`TSP_SEL_SECOND_LSB +: `TSP_SEL_W]),
    .pol_low    (pin_output_control_q[`TSP_BIT_POL_SECOND]),
    .od_mode    (pin_output_control_q[`TSP_BIT_OD_SECOND]),
    .drv_en     (aux_drive_second_q),
    .src_irq    (dev_irq),
    .src_env    (envelope_q),
    .src_led_a  (sync_q[S_LEDA]),
    .src_led_b  (sync_q[S_LEDB]),
    .src_wr_a   (wr_a_q),
    .src_wr_b   (wr_b_q),
    .src_wr_any (wr_any_q),
    .src_half   (half_rate_q),
    .src_osc    (sync_q[S_OSC]),
    .pin_o      (aux_out_second),
    .pin_oe     (aux_out_second_oe)
  );

endmodule
`default_nettype wire

//--- verif/tsp_line_load.sv
// Far-side listener on a shared timing line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module tsp_line_load (
  // Pad side
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Level seen by the listener
  output wire logic line
);
  // A released line floats up through the pull-up, never holds the last value
  assign line = pin_oe ? pin_o : 1'b1;
endmodule
`default_nettype wire

//--- verif/tsp_top_checker.sv
// Concurrent checks on the timing pin block ports
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.vh"
module tsp_top_checker #(
  parameter ADDR_W = 8,
  parameter DATA_W = 16
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Register port
  input wire logic              reg_wr_en,
  input wire logic              reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wr_data,
  input wire logic [DATA_W-1:0] reg_rd_data,
  input wire logic              reg_rd_valid,
  // Sources and pins
  input wire logic              dev_irq,
  input wire logic              aux_out_first,
  input wire logic              aux_out_first_oe,
  input wire logic              aux_out_second,
  input wire logic              aux_out_second_oe
);
  logic [15:0] ctl_q;
  logic [4:0]  sel1_q;
  logic [4:0]  sel2_q;
  logic        cfg6_q;
  logic [1:0]  age_q;
  logic        set_ok;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Shadow of the settings; pins only trusted once a write has had time to land
  always @(posedge sys_clk) begin
    if (rst) begin
      ctl_q  <= 16'h0000;
      sel1_q <= 5'h00;
      sel2_q <= 5'h00;
      cfg6_q <= 1'b0;
    end else if (reg_wr_en) begin
      if (reg_addr == `TSP_OFF_PIN_CTRL) ctl_q <= reg_wr_data & 16'h0307;
      if (reg_addr == `TSP_OFF_PIN_SEL) sel1_q <= reg_wr_data[4:0];
      if (reg_addr == `TSP_OFF_PIN_SEL) sel2_q <= reg_wr_data[12:8];
      if (reg_addr == `TSP_OFF_AUX_CFG) cfg6_q <= reg_wr_data[6];
    end
  end
  // Cycles since the last write, saturating
  always @(posedge sys_clk) begin
    if (rst || reg_wr_en) age_q <= 2'd0;
    else if (age_q != 2'd3) age_q <= age_q + 2'd1;
  end
  assign set_ok = (age_q == 2'd3);
  chk_rd_pulse: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read strobe gave no valid pulse");
  chk_rd_quiet: assert property (!reg_rd_valid |-> reg_rd_data == '0)
    else $error("read data not zero outside valid");
  chk_first_off: assert property (set_ok && !ctl_q[2] |-> !aux_out_first_oe)
    else $error("first pin drives while disabled");
  chk_second_off: assert property (set_ok && !cfg6_q |-> !aux_out_second_oe)
    else $error("second pin drives while disabled");
  chk_first_push: assert property (set_ok && ctl_q[2] && !ctl_q[1] |-> aux_out_first_oe)
    else $error("first pin not driving in push-pull");
  chk_irq_copy: assert property (set_ok && sel1_q == 5'h01 |-> aux_out_first == ($past(dev_irq) ^ ctl_q[0]))
    else $error("first pin does not follow interrupt");
  chk_const_level: assert property (set_ok && sel2_q[4:1] == 4'h8 |-> aux_out_second == (sel2_q[0] ^ ctl_q[8]))
    else $error("second pin constant level wrong");
  chk_od_quiet: assert property (set_ok && ctl_q[2] && ctl_q[1] && sel1_q == 5'h10 |-> !aux_out_first_oe)
    else $error("open-drain pin drives deasserted source");
  chk_unlisted_code: assert property (set_ok && sel1_q inside {5'h03, 5'h1F} |-> aux_out_first == ctl_q[0])
    else $error("unlisted code not deasserted");
  chk_od_drive: assert property (set_ok && cfg6_q && ctl_q[9] && sel2_q == 5'h11 |-> aux_out_second_oe)
    else $error("open-drain pin idle while asserted");
endmodule
bind tsp_top tsp_top_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .dev_irq(dev_irq),
  .aux_out_first(aux_out_first), .aux_out_first_oe(aux_out_first_oe), .aux_out_second(aux_out_second),
  .aux_out_second_oe(aux_out_second_oe));
`default_nettype wire

//--- verif/tsp_top_test.sv
// Self-checking bench for the timing pin block
`timescale 1ns/1ps
`default_nettype none
module tsp_top_test;
  typedef struct packed {logic [15:0] sel; logic [15:0] ctl; logic [15:0] cfg; logic [3:0] inp; logic [3:0] exp;} tsp_row_t;
  logic        sys_clk = 0, rst = 1, reg_wr_en = 0, reg_rd_en = 0, dev_irq = 0, slot_a_en = 0, slot_b_en = 0;
  logic        run_mode = 0, slot_a_busy = 0, slot_b_busy = 0, led_a = 0, led_b = 0;
  logic        data_a_tgl = 0, data_b_tgl = 0, osc_32k = 0;
  logic [7:0]  reg_addr = 0;
  logic [15:0] reg_wr_data = 0;
  wire  [15:0] reg_rd_data;
  wire         reg_rd_valid, p1, e1, p2, e2, line1;
  int          bad_count = 0, samples_checked = 0, cyc = 0;
  // Inputs {irq, led_a, led_b, osc}; expected {pin1, oe1, pin2, oe2}
  tsp_row_t    rows [0:9] = '{
    '{16'h1110, 16'h0004, 16'h0040, 4'h0, 4'h7}, '{16'h1110, 16'h0105, 16'h0040, 4'h0, 4'hD},
    '{16'h1110, 16'h0206, 16'h0040, 4'h0, 4'h3}, '{16'h0101, 16'h0004, 16'h0000, 4'h8, 4'hE},
    '{16'h1F03, 16'h0105, 16'h0040, 4'h0, 4'hF}, '{16'h0101, 16'h0000, 16'h0040, 4'h0, 4'h1},
    '{16'h1F11, 16'h0307, 16'h0040, 4'h0, 4'h6}, '{16'h0605, 16'h0004, 16'h0040, 4'h4, 4'hD},
    '{16'h0607, 16'h0004, 16'h0040, 4'h2, 4'hF}, '{16'h1313, 16'h0004, 16'h0040, 4'h1, 4'hF}};
  tsp_top dut (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .dev_irq(dev_irq),
    .slot_a_en(slot_a_en), .slot_b_en(slot_b_en), .run_mode(run_mode), .slot_a_busy(slot_a_busy),
    .slot_b_busy(slot_b_busy), .led_a(led_a), .led_b(led_b), .data_a_tgl(data_a_tgl), .data_b_tgl(data_b_tgl),
    .osc_32k(osc_32k), .aux_out_first(p1), .aux_out_first_oe(e1), .aux_out_second(p2), .aux_out_second_oe(e2));
  tsp_line_load u_load (.pin_o(p1), .pin_oe(e1), .line(line1));
  // 125 MHz clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One write strobe, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge sys_clk);
    reg_wr_en <= 0;
  endtask
  // Read data stands for one cycle only, so it is looked at right after the taking edge
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd_en <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 0;
    #1;
    chk({15'h0000, reg_rd_valid}, 16'h0001);
    chk(reg_rd_data, exp);
  endtask
  // Sample event helper: drive a slot line and let it cross the synchroniser
  task automatic slot(input logic b, input logic v);
    @(posedge sys_clk);
    if (b) slot_b_busy <= v;
    else slot_a_busy <= v;
    tick(6);
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 0;
    tick(1);
    chk({p1, e1, p2, e2}, 16'h0000);
    rd(8'h02, 16'h0000);
    rd(8'h0B, 16'h0000);
    rd(8'h4F, 16'h0000);
    $display("test reset done");
    // Reserved bits drop, unmapped place reads zero
    wr(8'h02, 16'hFFFF);
    wr(8'h0B, 16'hFFFF);
    wr(8'h4F, 16'hFFFF);
    wr(8'h33, 16'hFFFF);
    rd(8'h02, 16'h0307);
    rd(8'h0B, 16'h1F1F);
    rd(8'h4F, 16'h0040);
    rd(8'h33, 16'h0000);
    $display("test registers done");
    foreach (rows[i]) begin
      @(posedge sys_clk);
      {dev_irq, led_a, led_b, osc_32k} <= rows[i].inp;
      wr(8'h0B, rows[i].sel);
      wr(8'h02, rows[i].ctl);
      wr(8'h4F, rows[i].cfg);
      tick(4);
      chk({p1, e1, p2, e2}, rows[i].exp);
      chk(line1, rows[i].exp[2] ? rows[i].exp[3] : 1'b1);
    end
    $display("test rows done");
    // Envelope on the first pin, half-rate wave on the second
    wr(8'h0B, 16'h0F02);
    wr(8'h02, 16'h0004);
    @(posedge sys_clk);
    slot_a_en <= 1;
    slot_b_en <= 1;
    run_mode <= 1;
    tick(6);
    chk(p2, 0);
    slot(0, 1);
    chk(p1, 1);
    slot(0, 0);
    chk(p1, 1);
    slot(1, 1);
    slot(1, 0);
    chk(p1, 0);
    chk(p2, 1);
    $display("test envelope done");
    // Data-written flags: slot A on first pin, either slot on second
    wr(8'h0B, 16'h0E0C);
    slot(0, 1);
    @(posedge sys_clk);
    data_b_tgl <= 1;
    tick(6);
    chk(p1, 0);
    chk(p2, 1);
    slot(0, 0);
    @(posedge sys_clk);
    data_a_tgl <= 1;
    tick(6);
    chk(p1, 1);
    slot(1, 1);
    slot(1, 0);
    chk(p1, 1);
    slot(0, 1);
    chk({p1, p2}, 0);
    $display("test data flags done");
    // Reset in mid-run with toggle lines and slot A busy held high: no false events
    @(posedge sys_clk);
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    tick(1);
    chk({p1, e1, p2, e2}, 16'h0000);
    rd(8'h0B, 16'h0000);
    rd(8'h02, 16'h0000);
    rd(8'h4F, 16'h0000);
    wr(8'h0B, 16'h0E0C);
    wr(8'h02, 16'h0004);
    tick(6);
    chk({p1, e1, p2, e2}, 16'h0004);
    $display("test mid reset done");
    close_out();
  end
endmodule
`default_nettype wire
